// ===== inc/iaos_pkg.sv
// constants and carrier types for the interleaved converter output stage
package iaos_pkg;

  // word layout
  localparam int DATA_W = 12;
  localparam logic [11:0] CODE_POS_FULL = 12'h7FF; // most positive full scale
  localparam logic [11:0] CODE_ZERO = 12'h000;     // mid-scale zero
  localparam logic [11:0] CODE_NEG_FULL = 12'h800; // most negative full scale
  localparam logic [11:0] SIGN_FLIP = 12'h800;     // offset-binary to twos complement
  localparam logic [11:0] DATA_RST = 12'h000;
  localparam logic [11:0] DATA_COMP_RST = 12'hFFF;

  // timing
  localparam int LATENCY_CYC = 40;     // encode cycles from sample to output
  localparam int REF_CLK_MHZ = 100;
  localparam int RESET_MIN_NS = 200;   // least reset low time, kept by the far side
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int RESUME_MS = 600;      // longest time to resume after reset
  localparam int RESUME_CYC = RESUME_MS * REF_CLK_MHZ * 1000;

  // one sample travelling down the pipeline
  typedef struct packed {
    logic valid;
    logic chan_b;
    logic [DATA_W-1:0] data;
  } iaos_word_type;

  // one channel's differential output pins
  typedef struct packed {
    logic [DATA_W-1:0] bit_true;
    logic [DATA_W-1:0] bit_comp;
    logic ready_strobe_true;
    logic ready_strobe_comp;
  } iaos_chan_pins_type;

  localparam iaos_chan_pins_type PINS_RST = '{DATA_RST, DATA_COMP_RST, 1'b0, 1'b1};

  // operating modes of the output stage
  typedef enum logic [1:0] {
    MODE_RESUME = 2'b00,
    MODE_RUN = 2'b01,
    MODE_HOLD = 2'b10
  } iaos_mode_type;

endpackage

// ===== src/iaos_delay_line.sv
// fixed-length sample pipeline advanced by encode edges
`timescale 1ns/1ps
`default_nettype none
module iaos_delay_line import iaos_pkg::*; #(
  parameter int DEPTH = LATENCY_CYC
) (
  input wire logic ref_clk,             // system clock
  input wire logic rstn,                // synchronous reset, active low
  input wire logic shift_en,            // one-cycle pulse per encode edge
  input wire logic flush,               // drop every word in flight
  input wire iaos_word_type in_word,    // sample entering the pipeline
  output iaos_word_type out_word        // sample leaving after DEPTH shifts
);

  if (DEPTH < 2) begin : g_bad_depth
    $error("iaos_delay_line: DEPTH must be at least 2");
  end

  typedef struct packed {
    iaos_word_type [DEPTH-1:0] stage;
  } iaos_dly_state_type;

  iaos_dly_state_type st_r;
  iaos_dly_state_type st_nxt;

  // flush beats shift so a word never survives a hold or reset
  always_comb begin
    st_nxt = st_r;
    if (flush) begin
      for (int i = 0; i < DEPTH; i++) begin
        st_nxt.stage[i].valid = 1'b0; // R6
      end
    end else if (shift_en) begin
      st_nxt.stage = {st_r.stage[DEPTH-2:0], in_word}; // R15
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // word at the far end is the one presented on the next shift
  assign out_word = st_r.stage[DEPTH-1];

endmodule
`default_nettype wire

// ===== src/iaos_output_sync.sv
// output side of a dual-channel time-interleaved 12-bit converter
// Function
// R1: each sample is sent as 12-bit twos complement, 7FF at positive full scale, 000 at zero, 800 at negative.
// R2: a low level on the reset input resets the device and a high level lets it run.
// R3: the controller holds reset low for at least 200 ns each time.
// R4: after reset release the device resumes within 600 ms and data before that is invalid.
// R5: once output resumes, valid data appears only after 40 encode cycles of latency.
// R6: samples taken while the lead/lag hold is asserted are dropped and never reach the outputs.
// R7: the lead/lag hold aligns buffer capture and may arrive synchronous or asynchronous to encode.
// R8: an asynchronous lead/lag hold is held high by the far side for a minimum time.
// R9: while the hold is asserted both ready strobes stop, restarting only after release.
// R10: a floating reset input reads high and a floating lead/lag input reads low.
// R11: each channel drives its 12-bit word, bit 11 down to bit 0 as LSB, on true and complement pins.
// R12: channel B has its own differential ready strobe, true and complement.
// R13: channel A has its own differential ready strobe, true and complement.
// R14: channels A and B take alternate samples and together form the full-rate stream.
// R15: encode edge to matching output is exactly 40 encode cycles with no variation.
// R16: capture logic registers each word on its own channel strobe and merges A and B alternately.
`timescale 1ns/1ps
`default_nettype none
module iaos_output_sync import iaos_pkg::*; #(
  parameter int unsigned RESUME_CYCLES = RESUME_CYC, // ref_clk cycles to resume after reset
  parameter int LATENCY = LATENCY_CYC                // encode cycles of pipeline latency
) (
  input wire logic ref_clk,                  // 100 MHz system clock
  input wire logic rstn,                     // synchronous reset, active low
  input wire logic encode_clk,               // encode clock pin, asynchronous
  input wire logic lead_lag_hold,            // alignment hold pin, active high, asynchronous
  input wire logic [DATA_W-1:0] sample_code, // offset-binary quantizer code, ref_clk domain
  output iaos_chan_pins_type chan_a_pins,    // channel A data and ready strobe pairs
  output iaos_chan_pins_type chan_b_pins,    // channel B data and ready strobe pairs
  output logic data_valid_window             // high once resume time has elapsed
);

  if (RESUME_CYCLES < 1) begin : g_bad_resume
    $error("iaos_output_sync: RESUME_CYCLES must be at least 1");
  end
  if (LATENCY < 2) begin : g_bad_latency
    $error("iaos_output_sync: LATENCY must be at least 2");
  end

  localparam int CNT_W = (RESUME_CYCLES > 1) ? $clog2(RESUME_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RESUME_CYCLES - 1);

  typedef struct packed {
    logic enc_s1;
    logic enc_s2;
    logic enc_s3;
    logic hold_s1;
    logic hold_s2;
    iaos_mode_type mode;
    logic [CNT_W-1:0] resume_cnt;
    logic phase_b;
    logic valid_win;
    iaos_chan_pins_type pins_a;
    iaos_chan_pins_type pins_b;
  } iaos_top_state_type;

  localparam iaos_top_state_type ST_RST = '{
    enc_s1: 1'b0, enc_s2: 1'b0, enc_s3: 1'b0, hold_s1: 1'b0, hold_s2: 1'b0,
    mode: MODE_RESUME, resume_cnt: '0, phase_b: 1'b0, valid_win: 1'b0,
    pins_a: PINS_RST, pins_b: PINS_RST
  };

  iaos_top_state_type st_r;
  iaos_top_state_type st_nxt;
  iaos_word_type in_word;
  iaos_word_type out_word;
  logic enc_rise;
  logic hold_on;
  logic flush;

  // raw code 4095 maps to 7FF, 2048 to 000, 0 to 800
  function automatic logic [DATA_W-1:0] to_twos(input logic [DATA_W-1:0] raw);
    to_twos = raw ^ SIGN_FLIP; // R1
  endfunction

  // load a channel's pins; complement pins always mirror the true ones
  function automatic iaos_chan_pins_type drive_pins(input logic [DATA_W-1:0] data, input logic strobe);
    drive_pins.bit_true = data;         // R11
    drive_pins.bit_comp = ~data;        // R11
    drive_pins.ready_strobe_true = strobe;
    drive_pins.ready_strobe_comp = ~strobe;
  endfunction

  // encode passes three flops (two sync, one edge detect), hold passes two; an undriven hold pin is assumed pulled low outside
  assign enc_rise = st_r.enc_s2 & ~st_r.enc_s3;
  assign hold_on = st_r.hold_s2; // R7 R10
  // hold or the resume wait empties the pipeline, so output restarts after full latency
  assign flush = (st_r.mode != MODE_RUN) | hold_on; // R5 R6

  // sample entering the pipe, tagged with its interleave channel
  always_comb begin
    in_word.valid = (st_r.mode == MODE_RUN) & ~hold_on; // R6
    in_word.chan_b = st_r.phase_b;                      // R14
    in_word.data = to_twos(sample_code);                // R1
  end

  iaos_delay_line #(
    .DEPTH(LATENCY)
  ) u_pipe (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .shift_en(enc_rise),
    .flush(flush),
    .in_word(in_word),
    .out_word(out_word)
  );

  // synchronisers, mode sequencing and output pin drive
  always_comb begin
    st_nxt = st_r;
    st_nxt.enc_s1 = encode_clk;
    st_nxt.enc_s2 = st_r.enc_s1;
    st_nxt.enc_s3 = st_r.enc_s2;
    st_nxt.hold_s1 = lead_lag_hold;
    st_nxt.hold_s2 = st_r.hold_s1;
    unique case (st_r.mode)
      MODE_RESUME: begin
        // count out the whole resume time before any sample is taken
        if (st_r.resume_cnt == CNT_LAST) begin
          st_nxt.mode = MODE_RUN; // R4
          st_nxt.valid_win = 1'b1; // R4
        end else begin
          st_nxt.resume_cnt = st_r.resume_cnt + 1'b1;
        end
      end
      MODE_RUN: begin
        if (hold_on) begin
          st_nxt.mode = MODE_HOLD;
        end else if (enc_rise) begin
          st_nxt.phase_b = ~st_r.phase_b; // R14
        end
      end
      MODE_HOLD: begin
        // restart on channel A so capture buffers line up after each hold
        st_nxt.phase_b = 1'b0;
        if (!hold_on) begin
          st_nxt.mode = MODE_RUN; // R9
        end
      end
    endcase
    if (flush) begin
      // strobes idle; data pins keep their last word
      st_nxt.pins_a = drive_pins(st_r.pins_a.bit_true, 1'b0); // R9 R13
      st_nxt.pins_b = drive_pins(st_r.pins_b.bit_true, 1'b0); // R9 R12
    end else if (enc_rise) begin
      if (!out_word.valid) begin
        st_nxt.pins_a = drive_pins(st_r.pins_a.bit_true, 1'b0); // R5
        st_nxt.pins_b = drive_pins(st_r.pins_b.bit_true, 1'b0); // R5
      end else if (out_word.chan_b) begin
        st_nxt.pins_b = drive_pins(out_word.data, 1'b1);        // R12 R15
        st_nxt.pins_a = drive_pins(st_r.pins_a.bit_true, 1'b0); // R13
      end else begin
        st_nxt.pins_a = drive_pins(out_word.data, 1'b1);        // R13 R15
        st_nxt.pins_b = drive_pins(st_r.pins_b.bit_true, 1'b0); // R12
      end
    end
  end

  // low reset means device reset; high lets it run
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_r <= ST_RST; // R2
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chan_a_pins = st_r.pins_a;
  assign chan_b_pins = st_r.pins_b;
  assign data_valid_window = st_r.valid_win;

endmodule
`default_nettype wire

// ===== testbench/iaos_capture_model.sv
// capture logic model: registers each channel word on its own ready strobe
`timescale 1ns/1ps
`default_nettype none
module iaos_capture_model import iaos_pkg::*; (
  input wire logic ref_clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire iaos_chan_pins_type chan_a_pins, // channel A pins
  input wire iaos_chan_pins_type chan_b_pins, // channel B pins
  input wire logic data_valid_window, // data trusted only once high
  output logic [DATA_W-1:0] last_word, // most recent merged word
  output logic [15:0] word_count // words captured
);
  logic sa_r;
  logic sb_r;
  // a rising strobe marks a fresh word; strobes before the window are ignored
  always_ff @(posedge ref_clk) begin
    sa_r <= chan_a_pins.ready_strobe_true;
    sb_r <= chan_b_pins.ready_strobe_true;
    if (!rstn) begin
      last_word <= 12'h000;
      word_count <= 16'h0000;
    end else if (data_valid_window && chan_a_pins.ready_strobe_true && !sa_r) begin
      last_word <= chan_a_pins.bit_true;
      word_count <= word_count + 16'h0001;
    end else if (data_valid_window && chan_b_pins.ready_strobe_true && !sb_r) begin
      last_word <= chan_b_pins.bit_true;
      word_count <= word_count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/iaos_output_sync_asserts.sv
// concurrent checks on the converter output stage ports
`timescale 1ns/1ps
`default_nettype none
module iaos_output_sync_asserts import iaos_pkg::*; (
  input wire logic ref_clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic encode_clk, // encode clock pin
  input wire logic lead_lag_hold, // alignment hold pin
  input wire logic [DATA_W-1:0] sample_code, // quantizer code
  input wire iaos_chan_pins_type chan_a_pins, // channel A pins
  input wire iaos_chan_pins_type chan_b_pins, // channel B pins
  input wire logic data_valid_window // resume window elapsed
);
  wire logic sa = chan_a_pins.ready_strobe_true;
  wire logic sb = chan_b_pins.ready_strobe_true;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_data_pairs: assert property (chan_a_pins.bit_comp == ~chan_a_pins.bit_true && chan_b_pins.bit_comp == ~chan_b_pins.bit_true)
    else $error("data pair not complementary");
  a_strobe_pairs: assert property (chan_a_pins.ready_strobe_comp == !sa && chan_b_pins.ready_strobe_comp == !sb)
    else $error("strobe pair not complementary");
  a_strobe_excl: assert property (!(sa && sb))
    else $error("both strobes high");
  a_strobe_alt: assert property ($rose(sb) |-> $fell(sa))
    else $error("channel A strobe did not hand over");
  // hold needs two sync flops plus the output register before strobes stop
  a_hold_stop: assert property (lead_lag_hold [*5] |-> !sa && !sb)
    else $error("strobe during hold");
  a_early_quiet: assert property (!data_valid_window |-> !sa && !sb)
    else $error("strobe before valid window");
  a_window_stay: assert property (data_valid_window |=> data_valid_window)
    else $error("valid window dropped");
  a_reset_outs: assert property (disable iff (1'b0) !rstn |=> chan_a_pins == PINS_RST && chan_b_pins == PINS_RST)
    else $error("outputs not at reset value");
  c_strobe_a: cover property ($rose(sa));
  c_strobe_b: cover property ($rose(sb));
  c_hold_end: cover property ($fell(lead_lag_hold));
endmodule
bind iaos_output_sync iaos_output_sync_asserts iaos_output_sync_asserts_inst (.ref_clk(ref_clk), .rstn(rstn),
  .encode_clk(encode_clk), .lead_lag_hold(lead_lag_hold), .sample_code(sample_code),
  .chan_a_pins(chan_a_pins), .chan_b_pins(chan_b_pins), .data_valid_window(data_valid_window));
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the interleaved converter output stage
`timescale 1ns/1ps
`default_nettype none
module tb_top import iaos_pkg::*;;
  logic ref_clk = 1'b0;
  logic encode_clk = 1'b0;
  logic rstn = 1'b0;
  logic lead_lag_hold = 1'b0;
  logic [DATA_W-1:0] sample_code = 12'h000;
  iaos_chan_pins_type pa;
  iaos_chan_pins_type pb;
  logic dvw;
  logic [DATA_W-1:0] last_word;
  logic [15:0] word_count;
  int err_total = 0;
  int check_count = 0;
  // encode clock runs free and unrelated in phase to the system clock
  always #5 ref_clk = ~ref_clk;
  always #62.5 encode_clk = ~encode_clk;
  // short resume count keeps the run brief
  iaos_output_sync #(.RESUME_CYCLES(16), .LATENCY(40)) iaos_output_sync_inst (.ref_clk(ref_clk), .rstn(rstn),
    .encode_clk(encode_clk), .lead_lag_hold(lead_lag_hold), .sample_code(sample_code), .chan_a_pins(pa),
    .chan_b_pins(pb), .data_valid_window(dvw));
  iaos_capture_model iaos_capture_model_inst (.ref_clk(ref_clk), .rstn(rstn), .chan_a_pins(pa),
    .chan_b_pins(pb), .data_valid_window(dvw), .last_word(last_word), .word_count(word_count));
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // wide enough to hold both channels' pin structs in one compare
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic enc(input int n, input int c);
    repeat (n) @(posedge encode_clk);
    repeat (c) @(posedge ref_clk);
  endtask
  // reset long enough for the far side, then time the resume window
  task automatic t_reset();
    rstn <= 1'b0;
    // one spare cycle: the first call starts before the first edge
    repeat (RESET_MIN_CYC + 1) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk({pa, pb}, {PINS_RST, PINS_RST});
    chk(dvw, 1'b0);
    repeat (14) @(posedge ref_clk);
    #1;
    chk(dvw, 1'b0);
    repeat (6) @(posedge ref_clk);
    #1;
    chk(dvw, 1'b1);
  endtask
  // full-scale codes and latency: old word one edge early, new word on the 40th
  task automatic t_coding();
    logic [11:0] raw [4] = '{12'hFFF, 12'h800, 12'h7FF, 12'h000};
    logic [11:0] exp [4] = '{12'h7FF, 12'h000, 12'hFFF, 12'h800};
    logic [11:0] prev = 12'h800;
    enc(41, 1);
    for (int i = 0; i < 4; i++) begin
      enc(1, 1);
      sample_code <= raw[i];
      enc(39, 6);
      #1;
      chk(last_word, prev);
      enc(1, 6);
      #1;
      chk(last_word, exp[i]);
      prev = exp[i];
    end
  endtask
  // samples during hold are lost and the first word after release is channel A
  task automatic t_hold();
    enc(1, 5);
    lead_lag_hold <= 1'b1;
    sample_code <= 12'hFFF;
    enc(4, 5);
    lead_lag_hold <= 1'b0;
    sample_code <= 12'h800;
    #1;
    chk({pa.ready_strobe_true, pb.ready_strobe_true}, 2'b00);
    enc(40, 6);
    #1;
    chk({pa.ready_strobe_true, pb.ready_strobe_true}, 2'b00);
    enc(1, 6);
    #1;
    chk({pa.ready_strobe_true, pb.ready_strobe_true}, 2'b10);
    chk(last_word, 12'h000);
    chk({pa.bit_true, pa.bit_comp}, {12'h000, 12'hFFF});
    chk({pa.ready_strobe_comp, pb.ready_strobe_comp}, 2'b01);
  endtask
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
  initial begin
    t_reset();
    t_coding();
    t_hold();
    chk(word_count > 16'h0000, 1'b1);
    @(posedge ref_clk);
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
